// ### rtl/mcir_defs.svh
// Purpose: offsets, reset values, field positions and timing counts of the monitor config block
// Assumes: 200 MHz system clock
// Notes: offsets are the register pointer values seen by the serial bus front end
`ifndef MCIR_DEFS_SVH
`define MCIR_DEFS_SVH

`define MCIR_OFS_CONFIG 8'h40
`define MCIR_OFS_STATUS1 8'h41
`define MCIR_OFS_STATUS2 8'h42
`define MCIR_OFS_MASK1 8'h43
`define MCIR_OFS_MASK2 8'h44
`define MCIR_OFS_CASE_CLR 8'h46
`define MCIR_OFS_EXT_MODE 8'h4C

`define MCIR_RST_CONFIG 8'h08
`define MCIR_RST_ZERO 8'h00
`define MCIR_RST_EXT_MODE 8'h44

`define MCIR_CFG_RUN 0
`define MCIR_CFG_INT_EN 1
`define MCIR_CFG_SUSPEND 3
`define MCIR_CFG_SYS_RST 4
`define MCIR_CFG_CASE_PULSE 6
`define MCIR_CFG_RESTORE 7
`define MCIR_MASK2_RST_EN 7
`define MCIR_CASE_CLR_BIT 7
`define MCIR_EXT_EN_BIT 0

// status bits that exist, apart from second status bit 7 of the extended mode; reserved ones read zero
`define MCIR_STAT1_USED 8'hDF
`define MCIR_STAT2_USED 8'h13
`define MCIR_STAT2_TEMP_UNDER_LIMIT_FLAG 7

// pulse length: 20 ms at 5 ns period, rounded up
`define MCIR_PULSE_MS 20
`define MCIR_CLK_NS 5
`define MCIR_PULSE_CYCLES ((`MCIR_PULSE_MS * 1000000 + `MCIR_CLK_NS - 1) / `MCIR_CLK_NS)

`endif

// ### rtl/mcir_pkg.sv
// Purpose: types of the monitor config block
// Assumes: mcir_defs.svh holds the numbers
// Notes: none
package mcir_pkg;
    // register access request from the serial bus front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcir_req_s;

    // limit violation events, one-cycle or level, from the comparison engine
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
    } mcir_events_s;

    typedef enum logic [1:0] {MCIR_IDLE, MCIR_PULSE} mcir_pulse_e;
endpackage : mcir_pkg

// ### rtl/mcir_top.sv
// Purpose: configuration, alarm status and mask registers of the hardware monitor
// Assumes: bus front end gives a one-cycle request; events are on i_sys_clk
// Notes: case_open_input is a pin and is resynchronised here
// Notes on behaviour
// - config bit 0 runs monitoring, clear is standby
// - clearing run bit keeps alarm output asserted
// - entering run starts comparisons and scanning
// - config bit 1 enables alarm output pin
// - bit 3 suspends alarm and halts monitoring
// - bit 4 pulses system reset 20 ms, self-clears
// - reset pulse needs second mask bit 7
// - bit 6 pulses case-open pin 20 ms, self-clears
// - config bit 6 shared with intrusion-clear bit 7
// - bit 7 restores power-on values, reads zero
// - config resets 08, status and masks zero
// - first status latches supply limit crossings
// - first status bit 4 flags temperature error
// - first status bits 6,7 flag fan counts
// - second status latches 12 V, core supply
// - second status bit 4 flags case opened
// - second status bit 7 low temperature, extended
// - mask bit one blocks matching status flag
// - extended enable activates low-temperature flag
// - intrusion-clear register at 46h resets zero
`timescale 1ns/100ps
`include "mcir_defs.svh"

module mcir_top (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire mcir_pkg::mcir_req_s i_req,
    input wire mcir_pkg::mcir_events_s i_events,
    input wire logic i_status_read_clear,
    input wire logic i_case_open_input,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_monitor_run,
    output logic o_scan_start,
    output logic o_alarm_n,
    output logic o_sys_reset_n,
    output logic o_case_open_pulse_n,
    output logic o_ext_mode_en
);
    import mcir_pkg::*;

    localparam logic [31:0] PULSE_CYC = 32'(`MCIR_PULSE_CYCLES);

    // write strobe for one register offset
    function automatic logic wr_hit(input mcir_req_s r, input logic [7:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction : wr_hit

    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] stat1_reg, stat1_next;
    logic [7:0] stat2_reg, stat2_next;
    logic [7:0] mask1_reg, mask1_next;
    logic [7:0] mask2_reg, mask2_next;
    logic [6:0] case_rsv_reg, case_rsv_next;
    logic [7:0] ext_reg, ext_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic run_reg, run_next;
    logic scan_reg, scan_next;
    logic alarm_n_reg, alarm_n_next;
    logic sys_rst_n_reg, sys_rst_n_next;
    logic case_pulse_n_reg, case_pulse_n_next;
    logic [2:0] case_sync_reg;
    logic case_seen_reg, case_seen_next;
    mcir_pulse_e rst_st_reg, rst_st_next;
    mcir_pulse_e case_st_reg, case_st_next;
    logic [31:0] rst_cnt_reg, rst_cnt_next;
    logic [31:0] case_cnt_reg, case_cnt_next;
    logic restore;
    logic mon_active;
    logic case_rise;

    assign restore = wr_hit(i_req, `MCIR_OFS_CONFIG) && i_req.wdata[`MCIR_CFG_RESTORE];
    // monitoring runs only with run set and suspend clear
    assign mon_active = cfg_reg[`MCIR_CFG_RUN] && !cfg_reg[`MCIR_CFG_SUSPEND];
    // second and third stages agree high while the seen flag was low
    assign case_rise = case_sync_reg[1] && case_sync_reg[2] && !case_seen_reg;

    // three-stage synchroniser for the case-open pin
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            case_sync_reg <= 3'h0;
        end else begin
            case_sync_reg <= {case_sync_reg[1:0], i_case_open_input};
        end
    end

    // configuration, mask and extended-mode registers
    always_comb begin
        cfg_next = cfg_reg;
        mask1_next = mask1_reg;
        mask2_next = mask2_reg;
        case_rsv_next = case_rsv_reg;
        ext_next = ext_reg;
        if (restore) begin
            cfg_next = `MCIR_RST_CONFIG;
            mask1_next = `MCIR_RST_ZERO;
            mask2_next = `MCIR_RST_ZERO;
            case_rsv_next = 7'h00;
            ext_next = `MCIR_RST_EXT_MODE;
        end else begin
            if (wr_hit(i_req, `MCIR_OFS_CONFIG)) begin
                cfg_next = i_req.wdata;
                // pulse bits only arm while no pulse runs; reset needs its enable
                cfg_next[`MCIR_CFG_SYS_RST] = cfg_reg[`MCIR_CFG_SYS_RST] ||
                    (i_req.wdata[`MCIR_CFG_SYS_RST] && mask2_reg[`MCIR_MASK2_RST_EN]);
                cfg_next[`MCIR_CFG_CASE_PULSE] = cfg_reg[`MCIR_CFG_CASE_PULSE] ||
                    i_req.wdata[`MCIR_CFG_CASE_PULSE];
            end
            if (wr_hit(i_req, `MCIR_OFS_CASE_CLR)) begin
                case_rsv_next = i_req.wdata[6:0];
                cfg_next[`MCIR_CFG_CASE_PULSE] = cfg_reg[`MCIR_CFG_CASE_PULSE] ||
                    i_req.wdata[`MCIR_CASE_CLR_BIT];
            end
            if (wr_hit(i_req, `MCIR_OFS_MASK1)) begin
                mask1_next = i_req.wdata;
            end
            if (wr_hit(i_req, `MCIR_OFS_MASK2)) begin
                mask2_next = i_req.wdata;
            end
            if (wr_hit(i_req, `MCIR_OFS_EXT_MODE)) begin
                ext_next = i_req.wdata;
            end
            // self-clear when each pulse has ended
            if (rst_st_reg == MCIR_PULSE && rst_cnt_reg == 32'h0) begin
                cfg_next[`MCIR_CFG_SYS_RST] = 1'b0;
            end
            if (case_st_reg == MCIR_PULSE && case_cnt_reg == 32'h0) begin
                cfg_next[`MCIR_CFG_CASE_PULSE] = 1'b0;
            end
        end
        cfg_next[`MCIR_CFG_RESTORE] = 1'b0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cfg_reg <= `MCIR_RST_CONFIG;
            mask1_reg <= `MCIR_RST_ZERO;
            mask2_reg <= `MCIR_RST_ZERO;
            case_rsv_reg <= 7'h00;
            ext_reg <= `MCIR_RST_EXT_MODE;
        end else begin
            cfg_reg <= cfg_next;
            mask1_reg <= mask1_next;
            mask2_reg <= mask2_next;
            case_rsv_reg <= case_rsv_next;
            ext_reg <= ext_next;
        end
    end

    // status latching; a new event wins over a read-clear in the same cycle
    always_comb begin
        stat1_next = stat1_reg;
        stat2_next = stat2_reg;
        case_seen_next = case_sync_reg[1] && case_sync_reg[2] ? 1'b1 :
            (!case_sync_reg[1] && !case_sync_reg[2] ? 1'b0 : case_seen_reg);
        if (i_status_read_clear && i_req.rd) begin
            if (i_req.addr == `MCIR_OFS_STATUS1) begin
                stat1_next = 8'h00;
            end
            if (i_req.addr == `MCIR_OFS_STATUS2) begin
                stat2_next = 8'h00;
            end
        end
        if (restore) begin
            stat1_next = `MCIR_RST_ZERO;
            stat2_next = `MCIR_RST_ZERO;
        end else if (mon_active) begin
            // supplies, temperature and fans
            stat1_next = stat1_next | (i_events.first & `MCIR_STAT1_USED);
            stat2_next = stat2_next | (i_events.second & `MCIR_STAT2_USED);
            if (ext_reg[`MCIR_EXT_EN_BIT] && i_events.second[`MCIR_STAT2_TEMP_UNDER_LIMIT_FLAG]) begin
                stat2_next[`MCIR_STAT2_TEMP_UNDER_LIMIT_FLAG] = 1'b1;
            end
        end
        if (case_rise && !restore) begin
            stat2_next[4] = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            stat1_reg <= `MCIR_RST_ZERO;
            stat2_reg <= `MCIR_RST_ZERO;
            case_seen_reg <= 1'b0;
        end else begin
            stat1_reg <= stat1_next;
            stat2_reg <= stat2_next;
            case_seen_reg <= case_seen_next;
        end
    end

    // two pulse engines share one shape; counts load one below the 20 ms cycle count, as zero is counted too
    always_comb begin
        rst_st_next = rst_st_reg;
        rst_cnt_next = rst_cnt_reg;
        case_st_next = case_st_reg;
        case_cnt_next = case_cnt_reg;
        case (rst_st_reg)
            MCIR_IDLE: begin
                if (cfg_reg[`MCIR_CFG_SYS_RST]) begin
                    rst_st_next = MCIR_PULSE;
                    rst_cnt_next = PULSE_CYC - 32'h1;
                end
            end
            MCIR_PULSE: begin
                if (rst_cnt_reg == 32'h0) begin
                    rst_st_next = MCIR_IDLE;
                end else begin
                    rst_cnt_next = rst_cnt_reg - 32'h1;
                end
            end
            default: rst_st_next = MCIR_IDLE;
        endcase
        case (case_st_reg)
            MCIR_IDLE: begin
                if (cfg_reg[`MCIR_CFG_CASE_PULSE]) begin
                    case_st_next = MCIR_PULSE;
                    case_cnt_next = PULSE_CYC - 32'h1;
                end
            end
            MCIR_PULSE: begin
                if (case_cnt_reg == 32'h0) begin
                    case_st_next = MCIR_IDLE;
                end else begin
                    case_cnt_next = case_cnt_reg - 32'h1;
                end
            end
            default: case_st_next = MCIR_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            rst_st_reg <= MCIR_IDLE;
            case_st_reg <= MCIR_IDLE;
            rst_cnt_reg <= 32'h0;
            case_cnt_reg <= 32'h0;
        end else begin
            rst_st_reg <= rst_st_next;
            case_st_reg <= case_st_next;
            rst_cnt_reg <= rst_cnt_next;
            case_cnt_reg <= case_cnt_next;
        end
    end

    // outputs and read data; all registered
    always_comb begin
        run_next = mon_active;
        scan_next = mon_active && !run_reg;
        // the run bit does not enter here, so clearing it leaves the alarm asserted
        alarm_n_next = !(|(stat1_reg & ~mask1_reg) || |(stat2_reg & ~mask2_reg)) ||
            !cfg_reg[`MCIR_CFG_INT_EN] || cfg_reg[`MCIR_CFG_SUSPEND];
        rvalid_next = i_req.rd;
        // pins follow the next engine state, so the output flop adds no lag
        sys_rst_n_next = (rst_st_next != MCIR_PULSE);
        case_pulse_n_next = (case_st_next != MCIR_PULSE);
        case (i_req.addr)
            `MCIR_OFS_CONFIG: rdata_next = cfg_reg;
            `MCIR_OFS_STATUS1: rdata_next = stat1_reg & `MCIR_STAT1_USED;
            `MCIR_OFS_STATUS2: rdata_next = stat2_reg & (`MCIR_STAT2_USED | 8'h80);
            `MCIR_OFS_MASK1: rdata_next = mask1_reg;
            `MCIR_OFS_MASK2: rdata_next = mask2_reg;
            `MCIR_OFS_CASE_CLR: rdata_next = {cfg_reg[`MCIR_CFG_CASE_PULSE], case_rsv_reg};
            `MCIR_OFS_EXT_MODE: rdata_next = ext_reg;
            default: rdata_next = 8'h00;
        endcase
        if (!i_req.rd) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            run_reg <= 1'b0;
            scan_reg <= 1'b0;
            alarm_n_reg <= 1'b1;
            sys_rst_n_reg <= 1'b1;
            case_pulse_n_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            run_reg <= run_next;
            scan_reg <= scan_next;
            alarm_n_reg <= alarm_n_next;
            sys_rst_n_reg <= sys_rst_n_next;
            case_pulse_n_reg <= case_pulse_n_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rvalid = rvalid_reg;
    assign o_monitor_run = run_reg;
    assign o_scan_start = scan_reg;
    assign o_alarm_n = alarm_n_reg;
    assign o_sys_reset_n = sys_rst_n_reg;
    assign o_case_open_pulse_n = case_pulse_n_reg;
    assign o_ext_mode_en = ext_reg[`MCIR_EXT_EN_BIT];
endmodule : mcir_top

// ### verif/mcir_top_asserts.sv
// Purpose: port-level assertions of the monitor config block
// Assumes: one clock domain, synchronous active-low reset
// Notes: a config write shows at the outputs two edges later
`timescale 1ns/100ps
module mcir_top_asserts (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire mcir_pkg::mcir_req_s i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_monitor_run,
    input wire logic o_alarm_n,
    input wire logic o_sys_reset_n,
    input wire logic o_case_open_pulse_n,
    input wire logic o_ext_mode_en
);
    import mcir_pkg::*;
    logic cfg_wr;
    // restore writes left out: they reset everything instead
    assign cfg_wr = i_req.wr && i_req.addr == 8'h40 && !i_req.wdata[7];
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    reset_idle_a: assert property (disable iff (1'b0)
        !i_reset_n |=> o_alarm_n && o_sys_reset_n && o_case_open_pulse_n && !o_rvalid)
        else $error("outputs not idle in reset");
    run_follow_a: assert property (cfg_wr |-> ##2
        o_monitor_run == ($past(i_req.wdata[0], 2) && !$past(i_req.wdata[3], 2)))
        else $error("run output not following config");
    int_gate_a: assert property (cfg_wr && !i_req.wdata[1] |-> ##2 o_alarm_n)
        else $error("alarm active while disabled");
    suspend_quiet_a: assert property (cfg_wr && i_req.wdata[3] |-> ##2 o_alarm_n)
        else $error("alarm active while suspended");
    rst_hold_a: assert property ($fell(o_sys_reset_n) |=> !o_sys_reset_n [*8])
        else $error("reset pulse too short");
    case_hold_a: assert property ($fell(o_case_open_pulse_n) |=>
        !o_case_open_pulse_n [*8]) else $error("case pulse too short");
    ext_mode_a: assert property (i_req.wr && i_req.addr == 8'h4C |=>
        o_ext_mode_en == $past(i_req.wdata[0])) else $error("extended enable not stored");
    stat_reserved_a: assert property (i_req.rd && i_req.addr == 8'h42 |=>
        o_rvalid && o_rdata[6:5] == 2'h0 && o_rdata[3:2] == 2'h0)
        else $error("reserved status bits set");
    cover property ($fell(o_alarm_n));
    cover property ($fell(o_sys_reset_n));
    cover property ($rose(o_monitor_run));
endmodule : mcir_top_asserts
bind mcir_top mcir_top_asserts u_chk (.i_sys_clk, .i_reset_n, .i_req, .o_rdata, .o_rvalid,
    .o_monitor_run, .o_alarm_n, .o_sys_reset_n, .o_case_open_pulse_n, .o_ext_mode_en);

// ### verif/mcir_host.sv
// Purpose: host model issuing register accesses to the monitor config block
// Assumes: one-cycle strobe, answer one edge later
// Notes: strobe returns to zero between accesses
`timescale 1ns/100ps
module mcir_host (
    input wire logic i_sys_clk,
    output mcir_pkg::mcir_req_s o_req,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    import mcir_pkg::*;
    initial o_req = '0;
    // write: strobe held for exactly one sampling edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_sys_clk) o_req <= '0;
    endtask : write
    // read: data taken at the edge only if valid, so a lost answer reads unknown
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk) o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_sys_clk) o_req <= '0;
        @(posedge i_sys_clk) d = i_rvalid ? i_rdata : 8'hXX;
    endtask : read
endmodule : mcir_host

// ### verif/mcir_top_test.sv
// Purpose: self-checking bench of the monitor config block
// Assumes: host model owns the register strobe
// Notes: 20 ms pulses are watched only at their start
`timescale 1ns/100ps
module mcir_top_test;
    import mcir_pkg::*;
    logic i_sys_clk, i_reset_n, i_status_read_clear, i_case_open_input;
    mcir_req_s req;
    mcir_events_s events;
    logic [7:0] rdata;
    logic rvalid, run, scan, alarm_n, sys_rst_n, case_n, ext_en, seen;
    int n_fail = 0;
    int n_compared = 0;
    mcir_top u_dut (.i_sys_clk, .i_reset_n, .i_req(req), .i_events(events),
        .i_status_read_clear, .i_case_open_input, .o_rdata(rdata), .o_rvalid(rvalid),
        .o_monitor_run(run), .o_scan_start(scan), .o_alarm_n(alarm_n),
        .o_sys_reset_n(sys_rst_n), .o_case_open_pulse_n(case_n), .o_ext_mode_en(ext_en));
    mcir_host u_host (.i_sys_clk, .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        chk(d, exp);
    endtask : rchk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write(a, d);
    endtask : wr
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc
    // one-cycle limit events, as the comparison engine would give them
    task automatic ev(input logic [7:0] f, input logic [7:0] s);
        @(posedge i_sys_clk) events <= '{first: f, second: s};
        @(posedge i_sys_clk) events <= '0;
    endtask : ev
    task automatic t_regs;
        for (int a = 8'h41; a <= 8'h44; a++) rchk(8'(a), 8'h00);
        rchk(8'h40, 8'h08);
        rchk(8'h46, 8'h00);
        rchk(8'h00, 8'h00);
        wr(8'h43, 8'hFF);
        wr(8'h44, 8'h7F);
        wr(8'h41, 8'hFF);
        wr(8'h40, 8'h24);
        rchk(8'h43, 8'hFF);
        rchk(8'h44, 8'h7F);
        rchk(8'h41, 8'h00);
        rchk(8'h40, 8'h24);
    endtask : t_regs
    task automatic t_alarm;
        wr(8'h43, 8'h00);
        wr(8'h44, 8'h00);
        wr(8'h40, 8'h03);
        seen = 0;
        repeat (4) begin
            cyc(1);
            seen |= scan;
        end
        chk(8'(seen), 8'h01);
        chk(8'(run), 8'h01);
        ev(8'hFF, 8'hEF);
        rchk(8'h41, 8'hDF);
        rchk(8'h42, 8'h03);
        chk(8'(alarm_n), 8'h00);
        wr(8'h4C, 8'h01);
        ev(8'h00, 8'h80);
        rchk(8'h42, 8'h83);
        wr(8'h40, 8'h02);
        cyc(2);
        chk(8'(alarm_n), 8'h00);
        wr(8'h40, 8'h0A);
        cyc(2);
        chk(8'(alarm_n), 8'h01);
        rchk(8'h41, 8'hDF);
        wr(8'h40, 8'h02);
        wr(8'h43, 8'hFF);
        wr(8'h44, 8'hFF);
        cyc(2);
        chk(8'(alarm_n), 8'h01);
        wr(8'h43, 8'hFE);
        cyc(2);
        chk(8'(alarm_n), 8'h00);
        wr(8'h40, 8'h00);
        cyc(2);
        chk(8'(alarm_n), 8'h01);
        @(posedge i_sys_clk) i_status_read_clear <= 1'b1;
        rchk(8'h41, 8'hDF);
        rchk(8'h41, 8'h00);
        @(posedge i_sys_clk) i_status_read_clear <= 1'b0;
    endtask : t_alarm
    task automatic t_case_restore;
        @(posedge i_sys_clk) i_case_open_input <= 1'b1;
        cyc(8);
        rchk(8'h42, 8'h93);
        wr(8'h40, 8'h80);
        rchk(8'h40, 8'h08);
        for (int a = 8'h41; a <= 8'h44; a++) rchk(8'(a), 8'h00);
        rchk(8'h46, 8'h00);
        chk(8'(ext_en), 8'h00);
    endtask : t_case_restore
    task automatic t_pulses;
        wr(8'h40, 8'h10);
        cyc(3);
        chk(8'(sys_rst_n), 8'h01);
        wr(8'h44, 8'h80);
        wr(8'h40, 8'h10);
        cyc(3);
        chk(8'(sys_rst_n), 8'h00);
        rchk(8'h40, 8'h10);
        wr(8'h46, 8'h80);
        cyc(3);
        chk(8'(case_n), 8'h00);
        rchk(8'h40, 8'h50);
        rchk(8'h46, 8'h80);
    endtask : t_pulses
    task automatic finish_test;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        i_sys_clk = 0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    // far beyond the fewer than two hundred cycles the tests need
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        i_reset_n = 0;
        events = '0;
        i_status_read_clear = 0;
        i_case_open_input = 0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        t_regs();
        t_alarm();
        t_case_restore();
        t_pulses();
        finish_test();
    end
endmodule : mcir_top_test
